// ==== core/uctl_defs.svh ====
`ifndef UCTL_DEFS_SVH
`define UCTL_DEFS_SVH

// ****************************************************************
// Register indices; byte address is four times the index
// ****************************************************************
`define UCTL_IDX_TX_HOLD 12'h0b8
`define UCTL_IDX_RX_HOLD 12'h0b9
`define UCTL_IDX_LCS 12'h0ba
`define UCTL_IDX_RS 12'h0bb
`define UCTL_IDX_ICS 12'h0bc

// ****************************************************************
// Field positions of line_control_status
// ****************************************************************
`define UCTL_LCS_ERR 2
`define UCTL_LCS_RBF 1
`define UCTL_LCS_TBE 0

// ****************************************************************
// Field positions of receive_status
// ****************************************************************
`define UCTL_RS_OVR 7
`define UCTL_RS_FE 6
`define UCTL_RS_PE 5
`define UCTL_RS_SPARE 4
`define UCTL_RS_NINTH 3
`define UCTL_RS_ATTENTION_MODE 2
`define UCTL_RS_TRANSMITTING_FLAG 1
`define UCTL_RS_LINE 0

// ****************************************************************
// Reset values
// ****************************************************************
`define UCTL_RST_CFG 5'h00
`define UCTL_RST_ICS 8'h00
`define UCTL_RST_TBE 1'b1

// ****************************************************************
// Timing
// ****************************************************************
`define UCTL_CLK_HZ 10000000
`define UCTL_BAUD_HZ 9600
`define UCTL_OVERSAMPLE 16
`define UCTL_TICK_DIV (`UCTL_CLK_HZ / (`UCTL_OVERSAMPLE * `UCTL_BAUD_HZ))
`define UCTL_BIT_END 4'hf
`define UCTL_SHORT_END 4'hd
`define UCTL_HALF_END 4'h7

`endif

// ==== core/uctl_pkg.sv ====
package uctl_pkg;

  // Writable framing fields of line_control_status, bit 7 down to bit 3
  typedef struct packed {
    logic parity_enable;
    logic parity_select_hi;
    logic parity_select_lo;
    logic frame_len_sel_hi;
    logic frame_len_sel_lo;
  } uctl_frame_cfg_type;

  // irq_clock_source, bit 7 down to bit 0
  typedef struct packed {
    logic two_stop_sel;
    logic short_last_stop;
    logic tx_pin_enable;
    logic sync_mode;
    logic rx_ext_clock_sel;
    logic tx_ext_clock_sel;
    logic rx_irq_enable;
    logic tx_irq_enable;
  } uctl_irq_clk_type;

  // One received character handed from the receiver to the flags
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic ninth;
    logic parity_err;
    logic frame_err;
  } uctl_rx_char_type;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2
  } uctl_tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE, RX_START, RX_DATA, RX_STOP
  } uctl_rx_state_type;

endpackage

// ==== core/uctl_top.sv ====
`timescale 1ns/1ns
`include "uctl_defs.svh"
// Summary of operation
// - Parity select 00 odd, 01 even, 10 forced one, 11 forced zero.
// - In nine-bit framing the low parity-select bit is the ninth transmitted bit.
// - Frame length select 00 eight, 01 seven, 10 nine data bits; reset zero.
// - Parity not counted in data bits; hardware appends and checks it outside nine-bit framing.
// - Frame length select 11 loops transmitter into receiver with nine-bit framing.
// - Global error flag set on overrun, framing or parity error; read only.
// - Receive buffer full sets on character copy, clears on holding register read.
// - Transmit buffer empty sets on shifter load, clears on holding write, resets one.
// - Overrun, framing, parity flags set on error, clear on status read.
// - Ninth received bit is stored in a read-only status bit.
// - Attention bit is cleared by hardware on a character with ninth bit one.
// - Transmitting flag high while sending, drops after final stop bit.
// - Line fault bit sets on framing error, clears when receive input (pin, or transmit line in loopback) is high.
// - Two-stop select gives one or two transmitted stop bits.
// - Short-stop bit makes the last stop bit seven eighths long in asynchronous mode.
// - Transmit pin is driven only while the pin enable bit is set.
// - Mode select zero asynchronous, one synchronous; reset asynchronous.
// - Receiver clock from internal divider, or external pin when selected.
// - Transmitter clock from internal divider, or external pin when selected.
// - Receive interrupt enable gates the receive interrupt.
// - Transmit interrupt enable gates the transmit interrupt.
// - Transmit interrupt pending while buffer empty and enable both set.
// - Receive interrupt pending while buffer full and enable both set.
// - Asynchronous serial clock runs at sixteen times the bit rate.
module uctl_top
  import uctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_pin_i,
  input wire logic ext_clock_pin_i,
  output logic tx_pin_o,
  output logic tx_pin_oe_o,
  output logic tx_irq_o,
  output logic rx_irq_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int TICK_DIV = `UCTL_TICK_DIV;
  logic ack_reg, spare_reg, attention_mode_reg, tbe_reg, rbf_reg, ovr_reg, fe_reg, pe_reg;
  logic ninth_reg, line_reg, transmitting_flag_reg, tx_pin_reg, tx_oe_reg, tx_irq_reg, rx_irq_reg;
  logic ext_prev_reg, tx_par_reg;
  logic [31:0] dat_reg;
  uctl_frame_cfg_type cfg_reg;
  uctl_irq_clk_type ics_reg;
  logic [7:0] tx_hold_reg, rx_hold_reg, div_reg, lcs_rd, rs_rd;
  uctl_tx_state_type tx_state_reg;
  logic [3:0] tx_cnt_reg, tx_bit_reg, rx_cnt_reg, rx_bit_reg;
  logic [3:0] data_bits, bit_end, tx_end_cnt, rx_total;
  logic [8:0] tx_shift_reg;
  uctl_rx_state_type rx_state_reg;
  logic [9:0] rx_shift_reg, rx_aligned;
  uctl_rx_char_type rx_char_reg;
  logic bus_go, wr_go, sel_tx, sel_rx, sel_lcs, sel_rs, sel_ics, rd_rs, rd_rx, wr_tx;
  logic nine_bits, seven_bits, loopback, parity_on, int_tick, ext_rise, tx_tick, rx_tick;
  logic tx_last_stop, tx_end, tx_load, tx_line, rx_in;

  // Parity of seven or eight data bits for the chosen sense
  function automatic logic uctl_parity(input logic [7:0] d, input logic seven,
                                       input logic [1:0] sel);
    logic x;
    x = ^(seven ? {1'b0, d[6:0]} : d);
    case (sel)
      2'h0: uctl_parity = ~x; // Odd
      2'h1: uctl_parity = x; // Even
      2'h2: uctl_parity = 1'b1; // Mark
      default: uctl_parity = 1'b0; // Space
    endcase
  endfunction

  // ****************************************************************
  // Frame format decode
  // ****************************************************************
  // Loopback (11) shares the nine-bit path with plain nine-bit framing
  assign nine_bits = cfg_reg.frame_len_sel_hi;
  assign seven_bits = ~cfg_reg.frame_len_sel_hi & cfg_reg.frame_len_sel_lo;
  assign loopback = cfg_reg.frame_len_sel_hi & cfg_reg.frame_len_sel_lo;
  assign parity_on = cfg_reg.parity_enable & ~nine_bits;
  assign data_bits = nine_bits ? 4'h9 : (seven_bits ? 4'h7 : 4'h8);

  // ****************************************************************
  // Wishbone decode
  // ****************************************************************
  // One access per ack; the master's held request must not repeat effects
  assign bus_go = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_go = bus_go & wb_we_i & wb_sel_i[0];
  assign sel_tx = wb_adr_i[13:2] == `UCTL_IDX_TX_HOLD;
  assign sel_rx = wb_adr_i[13:2] == `UCTL_IDX_RX_HOLD;
  assign sel_lcs = wb_adr_i[13:2] == `UCTL_IDX_LCS;
  assign sel_rs = wb_adr_i[13:2] == `UCTL_IDX_RS;
  assign sel_ics = wb_adr_i[13:2] == `UCTL_IDX_ICS;
  assign rd_rs = bus_go & ~wb_we_i & sel_rs;
  assign rd_rx = bus_go & ~wb_we_i & sel_rx;
  assign wr_tx = wr_go & sel_tx;

  // Read views of the two mixed registers
  assign lcs_rd = {cfg_reg, (ovr_reg | fe_reg | pe_reg), rbf_reg, tbe_reg};
  assign rs_rd = {ovr_reg, fe_reg, pe_reg, spare_reg, ninth_reg, attention_mode_reg, transmitting_flag_reg,
                  line_reg};

  // Registered ack and read data, one wait state per access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_go;
      dat_reg <= 32'h0000_0000;
      if (bus_go && !wb_we_i) begin
        case (1'b1)
          sel_tx: dat_reg <= {24'h00_0000, tx_hold_reg};
          sel_rx: dat_reg <= {24'h00_0000, rx_hold_reg};
          sel_lcs: dat_reg <= {24'h00_0000, lcs_rd};
          sel_rs: dat_reg <= {24'h00_0000, rs_rd};
          sel_ics: dat_reg <= {24'h00_0000, ics_reg};
          default: dat_reg <= 32'h0000_0000; // Unmapped reads zero
        endcase
      end
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ****************************************************************
  // Software-only configuration
  // ****************************************************************
  // Read-only bits in these words ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= `UCTL_RST_CFG;
      ics_reg <= `UCTL_RST_ICS;
      spare_reg <= 1'b0;
      tx_hold_reg <= 8'h00;
    end else if (wr_go) begin
      if (sel_lcs) cfg_reg <= wb_dat_i[7:3];
      if (sel_ics) ics_reg <= wb_dat_i[7:0];
      if (sel_rs) spare_reg <= wb_dat_i[`UCTL_RS_SPARE];
      if (sel_tx) tx_hold_reg <= wb_dat_i[7:0];
    end
  end

  // ****************************************************************
  // Bit clock sources
  // ****************************************************************
  // Internal 16x tick; the prescaler and divisor registers are not modelled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 8'h00;
      ext_prev_reg <= 1'b0;
    end else begin
      div_reg <= int_tick ? 8'h00 : div_reg + 8'h01;
      ext_prev_reg <= ext_clock_pin_i;
    end
  end
  assign int_tick = div_reg == 8'(TICK_DIV - 1);
  assign ext_rise = ext_clock_pin_i & ~ext_prev_reg;
  assign tx_tick = ics_reg.tx_ext_clock_sel ? ext_rise : int_tick;
  assign rx_tick = ics_reg.rx_ext_clock_sel ? ext_rise : int_tick;
  // Async: sixteen ticks per bit; sync: one tick per bit
  assign bit_end = ics_reg.sync_mode ? 4'h0 : `UCTL_BIT_END;

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  assign tx_last_stop = (tx_state_reg == TX_STOP2) ||
                        (tx_state_reg == TX_STOP1 && !ics_reg.two_stop_sel);
  // Short last stop only makes sense with sixteen ticks per bit
  assign tx_end_cnt = (tx_last_stop && ics_reg.short_last_stop && !ics_reg.sync_mode) ?
                      `UCTL_SHORT_END : bit_end;
  assign tx_end = tx_tick && tx_last_stop && tx_cnt_reg == tx_end_cnt;
  // A load never meets a holding write in the same cycle, so no byte is lost
  assign tx_load = (tx_state_reg == TX_IDLE || tx_end) && !tbe_reg && !wr_tx;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_shift_reg <= 9'h000;
      tx_par_reg <= 1'b0;
      transmitting_flag_reg <= 1'b0;
    end else if (tx_load) begin
      tx_state_reg <= TX_START;
      tx_cnt_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_shift_reg <= {cfg_reg.parity_select_lo, tx_hold_reg};
      tx_par_reg <= uctl_parity(tx_hold_reg, seven_bits,
                                {cfg_reg.parity_select_hi, cfg_reg.parity_select_lo});
      transmitting_flag_reg <= 1'b1;
    end else if (tx_end) begin
      tx_state_reg <= TX_IDLE;
      transmitting_flag_reg <= 1'b0;
    end else if (tx_tick && tx_state_reg != TX_IDLE) begin
      tx_cnt_reg <= (tx_cnt_reg == tx_end_cnt) ? 4'h0 : tx_cnt_reg + 4'h1;
      if (tx_cnt_reg == tx_end_cnt) begin
        case (tx_state_reg)
          TX_START: tx_state_reg <= TX_DATA;
          TX_DATA: begin
            tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == data_bits - 4'h1) begin
              tx_state_reg <= parity_on ? TX_PARITY : TX_STOP1;
            end
          end
          TX_PARITY: tx_state_reg <= TX_STOP1;
          TX_STOP1: tx_state_reg <= TX_STOP2;
          default: tx_state_reg <= TX_IDLE;
        endcase
      end
    end
  end

  // Line level for the current bit
  always_comb begin
    case (tx_state_reg)
      TX_START: tx_line = 1'b0;
      TX_DATA: tx_line = tx_shift_reg[0];
      TX_PARITY: tx_line = tx_par_reg;
      default: tx_line = 1'b1;
    endcase
  end

  // Pin holds idle high in loopback so the far end sees nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_pin_reg <= 1'b1;
      tx_oe_reg <= 1'b0;
    end else begin
      tx_pin_reg <= tx_line | loopback;
      tx_oe_reg <= ics_reg.tx_pin_enable & ~loopback;
    end
  end
  assign tx_pin_o = tx_pin_reg;
  assign tx_pin_oe_o = tx_oe_reg;

  // ****************************************************************
  // Receiver
  // ****************************************************************
  assign rx_in = loopback ? tx_line : rx_pin_i;
  assign rx_total = data_bits + {3'h0, parity_on};
  assign rx_aligned = rx_shift_reg >> (4'ha - rx_total);

  // Start detect, half-bit recheck, then one mid-bit sample per bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 10'h000;
      rx_char_reg <= '0;
    end else begin
      rx_char_reg.valid <= 1'b0;
      if (rx_tick) begin
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
        case (rx_state_reg)
          RX_IDLE: begin
            rx_cnt_reg <= 4'h0;
            rx_bit_reg <= 4'h0;
            // Sync frames have no half-bit wait: the next tick is already data
            if (!rx_in) rx_state_reg <= ics_reg.sync_mode ? RX_DATA : RX_START;
          end
          RX_START: begin
            if (ics_reg.sync_mode || rx_cnt_reg == `UCTL_HALF_END) begin
              rx_cnt_reg <= 4'h0;
              rx_bit_reg <= 4'h0;
              rx_state_reg <= rx_in ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_cnt_reg == bit_end) begin
              rx_cnt_reg <= 4'h0;
              rx_shift_reg <= {rx_in, rx_shift_reg[9:1]};
              rx_bit_reg <= rx_bit_reg + 4'h1;
              if (rx_bit_reg == rx_total - 4'h1) rx_state_reg <= RX_STOP;
            end
          end
          RX_STOP: begin
            // Receiver needs only one stop bit whatever the transmit setting
            if (rx_cnt_reg == bit_end) begin
              rx_state_reg <= RX_IDLE;
              rx_char_reg.valid <= 1'b1;
              rx_char_reg.data <= seven_bits ? {1'b0, rx_aligned[6:0]} : rx_aligned[7:0];
              rx_char_reg.ninth <= nine_bits & rx_aligned[8];
              rx_char_reg.parity_err <= parity_on &&
                (seven_bits ? rx_aligned[7] : rx_aligned[8]) !=
                uctl_parity(rx_aligned[7:0], seven_bits,
                            {cfg_reg.parity_select_hi, cfg_reg.parity_select_lo});
              rx_char_reg.frame_err <= ~rx_in;
            end
          end
          default: rx_state_reg <= RX_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Receive holding register and receive flags
  // ****************************************************************
  // Overrun keeps the unread character; attention drops plain data frames
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_hold_reg <= 8'h00;
      rbf_reg <= 1'b0;
      ninth_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else begin
      if (rd_rx) rbf_reg <= 1'b0;
      if (rd_rs) ovr_reg <= 1'b0;
      if (rx_char_reg.valid && !(attention_mode_reg && nine_bits && !rx_char_reg.ninth)) begin
        if (rbf_reg && !rd_rx) begin
          ovr_reg <= 1'b1;
        end else begin
          rx_hold_reg <= rx_char_reg.data;
          ninth_reg <= rx_char_reg.ninth;
          rbf_reg <= 1'b1;
        end
      end
    end
  end

  // Framing, parity and line fault flags; a new error beats the read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fe_reg <= 1'b0;
      pe_reg <= 1'b0;
      line_reg <= 1'b0;
    end else begin
      if (rd_rs) begin
        fe_reg <= 1'b0;
        pe_reg <= 1'b0;
      end
      if (rx_in) line_reg <= 1'b0;
      if (rx_char_reg.valid && rx_char_reg.frame_err) begin
        fe_reg <= 1'b1;
        line_reg <= 1'b1;
      end
      if (rx_char_reg.valid && rx_char_reg.parity_err) pe_reg <= 1'b1;
    end
  end

  // Attention: software sets or clears, hardware clears on a marked frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attention_mode_reg <= 1'b0;
    end else if (rx_char_reg.valid && nine_bits && rx_char_reg.ninth) begin
      attention_mode_reg <= 1'b0;
    end else if (wr_go && sel_rs) begin
      attention_mode_reg <= wb_dat_i[`UCTL_RS_ATTENTION_MODE];
    end
  end

  // ****************************************************************
  // Transmit buffer empty and interrupt requests
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tbe_reg <= `UCTL_RST_TBE;
    end else if (tx_load) begin
      tbe_reg <= 1'b1;
    end else if (wr_tx) begin
      tbe_reg <= 1'b0;
    end
  end

  // Requests follow flag and enable with one cycle of delay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_irq_reg <= 1'b0;
      rx_irq_reg <= 1'b0;
    end else begin
      tx_irq_reg <= tbe_reg & ics_reg.tx_irq_enable;
      rx_irq_reg <= rbf_reg & ics_reg.rx_irq_enable;
    end
  end
  assign tx_irq_o = tx_irq_reg;
  assign rx_irq_o = rx_irq_reg;

endmodule // uctl_top

// ==== sim/uctl_asserts.sv ====
`timescale 1ns/1ns
// ******
// Bus and pin checks
// ******
module uctl_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tx_pin_o,
  input wire logic tx_pin_oe_o,
  input wire logic tx_irq_o,
  input wire logic rx_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // One ack pulse, one cycle after the request
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  rdata_width_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits");
  // Leaving reset the pin is released and idle high
  reset_out_a: assert property (
    $fell(rst_i) |-> !tx_irq_o && !rx_irq_o && !tx_pin_oe_o && tx_pin_o)
    else $error("outputs not quiet after reset");
  // Only software accesses remove a request or move the pin enable
  rx_irq_drop_a: assert property (
    $fell(rx_irq_o) |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("rx irq fell without access");
  tx_irq_drop_a: assert property (
    $fell(tx_irq_o) |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("tx irq fell without access");
  oe_cause_a: assert property (
    $changed(tx_pin_oe_o) |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("pin enable moved without access");
  c_rx_irq: cover property ($rose(rx_irq_o));
  c_tx_irq: cover property ($rose(tx_irq_o));
  c_oe: cover property ($rose(tx_pin_oe_o));
endmodule // uctl_asserts
bind uctl_top uctl_asserts chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_pin_o(tx_pin_o),
  .tx_pin_oe_o(tx_pin_oe_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));

// ==== sim/uctl_remote.sv ====
`timescale 1ns/1ns
// ******
// Remote station
// ******
module uctl_remote (
  input wire logic clk_i,
  input wire logic tx_pin_i,
  output logic rx_pin_o = 1'b1,
  output logic ext_clk_o = 1'b0
);
  logic [1:0] div_reg = 2'h0;
  // Baud clock at 16x: a tick every 4 clocks, so a bit is 64 clocks
  always @(posedge clk_i) begin
    div_reg <= div_reg + 2'h1;
    ext_clk_o <= div_reg[1];
  end
  // Start bit, then n bits LSB first; stops come in v, line idles high
  task automatic send(input logic [11:0] v, input int n, input int bc);
    @(posedge clk_i);
    rx_pin_o <= 1'b0;
    repeat (bc) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      rx_pin_o <= v[i];
      repeat (bc) @(posedge clk_i);
    end
    rx_pin_o <= 1'b1;
    repeat (bc) @(posedge clk_i);
  endtask
  // Samples mid-bit; a missing start leaves the result unknown
  task automatic get(output logic [11:0] v, input int n, input int bc);
    int t;
    t = 0;
    v = 'x;
    while (tx_pin_i !== 1'b0 && t < 5000) begin
      @(posedge clk_i);
      t++;
    end
    if (t < 5000) begin
      v = 12'h0;
      repeat (bc / 2) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
        repeat (bc) @(posedge clk_i);
        v[i] = tx_pin_i;
      end
    end
  endtask
endmodule // uctl_remote

// ==== sim/tb.sv ====
`timescale 1ns/1ns
`include "uctl_defs.svh"
// ******
// Testbench
// ******
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [13:0] adr = 14'h0;
  logic [7:0] wd = 8'h0;
  logic [31:0] rdat;
  logic ack, tx_pin, oe, tx_irq, rx_irq, rx_pin, ext_clk;
  logic [7:0] rd, d;
  logic [11:0] v, e;
  logic [15:0] cfg [6] = '{16'h2f80, 16'h6fa0, 16'h2fc0, 16'h2fe0, 16'h2f88, 16'haf30};
  int errors = 0;
  int num_checks = 0;
  int k;
  always #50 clk_i = ~clk_i;
  uctl_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i({24'h0, wd}),
    .wb_dat_o(rdat), .wb_ack_o(ack), .rx_pin_i(rx_pin), .ext_clock_pin_i(ext_clk),
    .tx_pin_o(tx_pin), .tx_pin_oe_o(oe), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
  uctl_remote rem (.clk_i(clk_i), .tx_pin_i(tx_pin), .rx_pin_o(rx_pin),
    .ext_clk_o(ext_clk));
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One classic cycle; holds until ack is sampled
  task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] x);
    int t;
    t = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wd <= x;
    @(posedge clk_i);
    while (ack !== 1'b1 && t < 20) begin
      @(posedge clk_i);
      t++;
    end
    rd = rdat[7:0];
    cyc <= 1'b0;
    @(posedge clk_i);
    if (t == 20) begin
      check("ack", ack, 1'b1);
      end_sim();
    end
  endtask
  task automatic wait_rx;
    int t;
    t = 0;
    while (rx_irq !== 1'b1 && t < 30000) begin
      @(posedge clk_i);
      t++;
    end
    check("rx_irq", rx_irq, 1'b1);
    if (t == 30000) end_sim();
  endtask
  // Reference frame: data, parity or ninth bit, stops; returns bit count
  function automatic int frame(input logic [7:0] c, input logic [7:0] x,
      input logic two, output logic [11:0] f);
    int n;
    f = {4'h0, x};
    n = (c[4:3] == 2'b01) ? 7 : 8;
    if (n == 7) f[7] = 1'b0;
    if (c[4:3] == 2'b10) begin
      f[8] = c[5];
      n = 9;
    end else if (c[7]) begin
      f[n] = c[6] ? ~c[5] : (^f[7:0]) ^ ~c[5];
      n++;
    end
    f[n] = 1'b1;
    f[n + 1] = two;
    return two ? n + 2 : n + 1;
  endfunction
  initial begin
    void'($urandom(32'h940d70d2));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset contents, unmapped read, stored bits
    bus(0, `UCTL_IDX_LCS, 0);
    check("lcs", rd, 8'h01);
    bus(0, `UCTL_IDX_RS, 0);
    check("rs", rd, 8'h00);
    bus(0, 12'h0ff, 0);
    check("hole", rd, 8'h00);
    bus(1, `UCTL_IDX_RS, 8'hff);
    bus(0, `UCTL_IDX_RS, 0);
    check("rs", rd, 8'h14);
    bus(1, `UCTL_IDX_RS, 8'h00);
    d = $urandom;
    bus(1, `UCTL_IDX_ICS, d);
    bus(0, `UCTL_IDX_ICS, 0);
    check("ics", rd, d);
    $display("register test done");
    // Transmit each parity mode, seven, nine bits, two stops
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      bus(1, `UCTL_IDX_ICS, cfg[i][15:8]);
      bus(1, `UCTL_IDX_LCS, cfg[i][7:0]);
      k = frame(cfg[i][7:0], d, cfg[i][15], e);
      bus(1, `UCTL_IDX_TX_HOLD, d);
      bus(0, `UCTL_IDX_RS, 0);
      check("busy", rd[1], 1'b1);
      rem.get(v, k, 64);
      check("txframe", v, e);
      if (v[0] === 1'bx) end_sim();
      repeat (100) @(posedge clk_i);
      bus(0, `UCTL_IDX_RS, 0);
      check("busy", rd[1], 1'b0);
    end
    check("oe", oe, 1'b1);
    check("tx_irq", tx_irq, 1'b1);
    $display("transmit test done");
    // Receive good, bad parity, bad stop, then overrun
    bus(1, `UCTL_IDX_ICS, 8'h0f);
    bus(1, `UCTL_IDX_LCS, 8'ha0);
    for (int m = 0; m < 4; m++) begin
      d = $urandom;
      k = frame(8'ha0, d, 1'b0, e);
      if (m == 1) e[8] = ~e[8];
      if (m == 2) e[9] = 1'b0;
      rem.send(e, k, 64);
      if (m == 3) rem.send(e ^ 12'h0ff, k, 64);
      wait_rx();
      bus(0, `UCTL_IDX_LCS, 0);
      check("lcs", rd, m ? 8'ha7 : 8'ha3);
      bus(0, `UCTL_IDX_RS, 0);
      check("rs", rd, m ? 8'h10 << m : 8'h00);
      bus(0, `UCTL_IDX_RX_HOLD, 0);
      check("rxdata", rd, d);
      bus(0, `UCTL_IDX_RS, 0);
      check("rs", rd, 8'h00);
      check("rx_irq", rx_irq, 1'b0);
    end
    // Attention drops ninth-bit-zero characters
    bus(1, `UCTL_IDX_LCS, 8'h10);
    bus(1, `UCTL_IDX_RS, 8'h04);
    rem.send(12'h2ab, 10, 64);
    repeat (40) @(posedge clk_i);
    check("rx_irq", rx_irq, 1'b0);
    rem.send(12'h3cd, 10, 64);
    wait_rx();
    bus(0, `UCTL_IDX_RS, 0);
    check("rs", rd, 8'h08);
    bus(0, `UCTL_IDX_RX_HOLD, 0);
    check("rxdata", rd, 8'hcd);
    $display("receive test done");
    // Loopback keeps the pin released
    bus(1, `UCTL_IDX_ICS, 8'h2f);
    bus(1, `UCTL_IDX_LCS, 8'h18);
    d = $urandom;
    bus(1, `UCTL_IDX_TX_HOLD, d);
    wait_rx();
    check("pin", {oe, tx_pin}, 2'b01);
    bus(0, `UCTL_IDX_RX_HOLD, 0);
    check("rxdata", rd, d);
    // Internal baud clock, then masking the receive request
    bus(1, `UCTL_IDX_ICS, 8'h03);
    bus(1, `UCTL_IDX_LCS, 8'h00);
    d = $urandom;
    k = frame(8'h00, d, 1'b0, e);
    rem.send(e, k, 1040);
    wait_rx();
    bus(1, `UCTL_IDX_ICS, 8'h01);
    repeat (3) @(posedge clk_i);
    check("irqs", {rx_irq, tx_irq}, 2'b01);
    bus(0, `UCTL_IDX_RX_HOLD, 0);
    check("rxdata", rd, d);
    // Synchronous receive: one external tick per bit
    bus(1, `UCTL_IDX_ICS, 8'h1a);
    d = $urandom;
    k = frame(8'h00, d, 1'b0, e);
    rem.send(e, k, 4);
    wait_rx();
    bus(0, `UCTL_IDX_RX_HOLD, 0);
    check("rxdata", rd, d);
    $display("clock test done");
    end_sim();
  end
endmodule // tb
